//--- design/srdp_regs.vh
`ifndef SRDP_REGS_VH
`define SRDP_REGS_VH
// ==========================================
// Character codes
`define SRDP_CH_S      8'h53
`define SRDP_CH_S_LC   8'h73
`define SRDP_CH_CR     8'h0D
`define SRDP_CH_LF     8'h0A
`define SRDP_CH_NUL    8'h00
// ==========================================
// Record types; data and termination are acted upon, header is skipped
`define SRDP_TYPE_DATA 4'h1
`define SRDP_TYPE_TERM 4'h9
`define SRDP_TYPE_HDR  4'h0
// ==========================================
// Field sizes in bytes for the 16-bit address format
`define SRDP_ADDR_BYTES 8'h02
`define SRDP_SUM_BYTES  8'h01
`endif

//--- design/srdp_parser.v
`timescale 1ns/1ps
// Notes on behaviour
// - Each byte arrives as two hex characters, high nibble first.
// - Record opens with letter S and one type digit.
// - Length counts address, data and checksum bytes only.
// - Address field is two, three or four bytes; loader uses two.
// - Checksum equals low byte of complemented sum of length, address, data.
// - CR, LF and NUL after a record are ignored.
// - Leading characters before the S are skipped.
// - Only S1 data and S9 termination records are acted upon.
// - Everything before the first S1 leaves memory untouched.
// - S1 data bytes go to consecutive addresses from record address.
// - S9 address is captured as entry point at transfer end.
// - Types S2 to S8 are never written to memory.
// - Every character travels as its ASCII code.
// - Byte count and checksum together confirm each S1 and S9 record.
`include "srdp_regs.vh"

// ==========================================
// Overview
// Characters arrive one per handshake
// Parser hunts for a record start letter
// Type digit picks body, skip or hunt
// Body digits pair up into bytes
// Bytes are counted from the length byte
// Address bytes land high first
// Data bytes go out through a small buffer
// Checksum byte closes the record
//
// ==========================================
// Byte index within a record body
// Index 0: length byte
// Index 1: address high byte
// Index 2: address low byte
// Index 3 up to length-1: data bytes
// Index equal to length: checksum byte
// Index is eight bits wide
// A length of 255 still fits the index
//
// ==========================================
// Running sum
// Cleared on the type digit
// Length, address and data bytes added
// Checksum byte itself never added
// Its complement compared against the checksum byte
// Short length fails even with good sum
//
// ==========================================
// Buffer toward memory
// Two words deep, head always in slot 0
// Pop shifts slot 1 down into slot 0
// Full buffer holds back the second digit
// So no data byte is ever dropped
// First digit is never stalled
// Hence a stall costs one character slot
//
// ==========================================
// Known limitations
// Writes are not rolled back on bad sum
// Memory may hold bytes of a bad record
// Skipped records are not sum checked
// Only the two-byte address form is kept
// Three and four byte forms are skipped
// Done and error hold until reset
// Characters after the end are swallowed
//
// ==========================================
// Status outputs
// Busy rises with the first good data record
// Busy falls at done or at error
// Started stays high once set
// Record count steps once per good S1 data record
// Count wraps after 255 records
// Entry address loads at done only
//
// ==========================================
// Timing
// One character taken per clock at most
// Data word visible one clock after its digit
// Status settles on the checksum's last digit
// No internal timers or long counters

module srdp_parser #(
  parameter ADDR_W = 16
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              rst_n,
  // Character stream from host
  input  wire              char_valid,
  input  wire [7:0]        char_data,
  output wire              char_ready,
  // Memory write port
  output wire              mem_valid,
  output wire [ADDR_W-1:0] mem_addr,
  output wire [7:0]        mem_data,
  input  wire              mem_ready,
  // Status
  output reg               busy_r,
  output reg               done_r,
  output reg               error_r,
  output reg  [ADDR_W-1:0] entry_addr_r,
  output reg               started_r,
  output reg  [7:0]        rec_count_r
);

  // ==========================================
  // States
  localparam ST_IDLE = 6'b000001;
  localparam ST_TYPE = 6'b000010;
  localparam ST_BODY = 6'b000100;
  localparam ST_DONE = 6'b001000;
  localparam ST_ERR  = 6'b010000;
  localparam ST_SKIP = 6'b100000;

  // Hex digit test and value, case blind
  function [4:0] srdp_hex;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        srdp_hex = {1'b1, c[3:0]};
      else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
        srdp_hex = {1'b1, c[3:0] + 4'h9};
      else
        srdp_hex = 5'h00;
    end
  endfunction

  reg  [5:0]        state_r;
  reg  [3:0]        type_r;
  reg  [3:0]        hi_nib_r;
  reg               half_r;
  reg  [7:0]        len_r;
  reg  [7:0]        idx_r;
  reg  [7:0]        sum_r;
  reg  [ADDR_W-1:0] addr_r;

  // ==========================================
  // Two-entry buffer toward memory
  reg  [ADDR_W+7:0] buf_q0_r;
  reg  [ADDR_W+7:0] buf_q1_r;
  reg  [1:0]        buf_cnt_r;
  wire              buf_in_valid;
  wire              buf_in_ready;
  wire              buf_pop;
  wire [ADDR_W+7:0] buf_in_word;

  assign buf_in_ready = (buf_cnt_r != 2'd2);
  assign buf_pop      = mem_valid && mem_ready;
  assign mem_valid    = (buf_cnt_r != 2'd0);
  assign mem_addr     = buf_q0_r[ADDR_W+7:8];
  assign mem_data     = buf_q0_r[7:0];

  // Buffer storage; head in q0, shifted on pop
  always @(posedge core_clk) begin
    if (!rst_n) begin
      buf_cnt_r <= 2'd0;
      buf_q0_r  <= {(ADDR_W+8){1'b0}};
      buf_q1_r  <= {(ADDR_W+8){1'b0}};
    end else begin
      case ({buf_in_valid && buf_in_ready, buf_pop})
        2'b10: begin
          if (buf_cnt_r == 2'd0)
            buf_q0_r <= buf_in_word;
          else
            buf_q1_r <= buf_in_word;
          buf_cnt_r <= buf_cnt_r + 2'd1;
        end
        2'b01: begin
          buf_q0_r  <= buf_q1_r;
          buf_cnt_r <= buf_cnt_r - 2'd1;
        end
        2'b11: begin
          if (buf_cnt_r == 2'd1)
            buf_q0_r <= buf_in_word;
          else begin
            buf_q0_r <= buf_q1_r;
            buf_q1_r <= buf_in_word;
          end
        end
        default: begin
          buf_cnt_r <= buf_cnt_r;
        end
      endcase
    end
  end

  // ==========================================
  // Byte assembly
  wire [4:0] hx      = srdp_hex(char_data);
  wire [7:0] cur_byte = {hi_nib_r, hx[3:0]};
  wire       in_body  = (state_r == ST_BODY);
  // Data byte position: after length (idx 0) and two address bytes
  wire       is_data  = (idx_r > `SRDP_ADDR_BYTES) && (idx_r < len_r);
  wire       byte_end = in_body && half_r && hx[4];
  wire       wr_byte  = byte_end && is_data && (type_r == `SRDP_TYPE_DATA);
  // Stall characters only while the buffer cannot take a data byte
  wire       stall    = in_body && half_r && is_data && (type_r == `SRDP_TYPE_DATA) && !buf_in_ready;

  assign char_ready   = !stall;
  assign buf_in_valid = char_valid && wr_byte;
  assign buf_in_word  = {addr_r, cur_byte};
  wire   take         = char_valid && char_ready;
  wire   is_term      = (char_data == `SRDP_CH_CR) || (char_data == `SRDP_CH_LF) ||
                        (char_data == `SRDP_CH_NUL);

  // ==========================================
  // Record parser; non-S1/S9 types are read through but skipped
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_r      <= ST_IDLE;
      type_r       <= 4'h0;
      hi_nib_r     <= 4'h0;
      half_r       <= 1'b0;
      len_r        <= 8'h00;
      idx_r        <= 8'h00;
      sum_r        <= 8'h00;
      addr_r       <= {ADDR_W{1'b0}};
      busy_r       <= 1'b0;
      done_r       <= 1'b0;
      error_r      <= 1'b0;
      entry_addr_r <= {ADDR_W{1'b0}};
      started_r    <= 1'b0;
      rec_count_r  <= 8'h00;
    end else if (take) begin
      case (state_r)
        ST_IDLE: begin
          // Line numbers, CR, LF, NUL and stray text fall through here
          if (char_data == `SRDP_CH_S || char_data == `SRDP_CH_S_LC)
            state_r <= ST_TYPE;
        end
        ST_TYPE: begin
          if (hx[4] && char_data <= 8'h39) begin
            type_r <= hx[3:0];
            half_r <= 1'b0;
            idx_r  <= 8'h00;
            sum_r  <= 8'h00;
            if (hx[3:0] == `SRDP_TYPE_DATA || hx[3:0] == `SRDP_TYPE_TERM)
              state_r <= ST_BODY;
            else
              state_r <= ST_SKIP;
          end else
            state_r <= ST_IDLE; // Not a record start after all
        end
        ST_SKIP: begin
          // Header and unused types are drained until a line end; before
          // the first S1 this is harmless, after it the sender is trusted
          if (is_term)
            state_r <= ST_IDLE;
        end
        ST_BODY: begin
          if (!hx[4]) begin
            state_r <= ST_ERR;
            error_r <= 1'b1;
            busy_r  <= 1'b0;
          end else if (!half_r) begin
            hi_nib_r <= hx[3:0];
            half_r   <= 1'b1;
          end else begin
            half_r <= 1'b0;
            idx_r  <= idx_r + 8'h01;
            if (idx_r == 8'h00)
              len_r <= cur_byte;
            else if (idx_r == 8'h01)
              addr_r <= {cur_byte, addr_r[7:0]};
            else if (idx_r == 8'h02)
              addr_r <= {addr_r[ADDR_W-1:8], cur_byte};
            else if (is_data)
              addr_r <= addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
            if (idx_r == 8'h00 || idx_r < len_r)
              sum_r <= sum_r + cur_byte;
            // Final byte: checksum against count-bounded running sum
            if (idx_r != 8'h00 && idx_r == len_r) begin
              if (cur_byte != ~sum_r || len_r < (`SRDP_ADDR_BYTES + `SRDP_SUM_BYTES)) begin
                state_r <= ST_ERR;
                error_r <= 1'b1;
                busy_r  <= 1'b0;
              end else if (type_r == `SRDP_TYPE_TERM) begin
                entry_addr_r <= addr_r;
                state_r      <= ST_DONE;
                done_r       <= 1'b1;
                busy_r       <= 1'b0;
              end else begin
                started_r   <= 1'b1;
                busy_r      <= 1'b1;
                rec_count_r <= rec_count_r + 8'h01;
                state_r     <= ST_IDLE;
              end
            end
          end
        end
        default: begin
          // Done and error hold until reset
          state_r <= state_r;
        end
      endcase
    end
  end

endmodule

//--- sim/srdp_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checks on the record parser
module srdp_chk #(
  parameter ADDR_W = 16
) (
  // Clock and reset
  input wire              core_clk,
  input wire              rst_n,
  // Character stream
  input wire              char_valid,
  input wire [7:0]        char_data,
  input wire              char_ready,
  // Memory write port
  input wire              mem_valid,
  input wire [ADDR_W-1:0] mem_addr,
  input wire [7:0]        mem_data,
  input wire              mem_ready,
  // Status
  input wire              busy_r,
  input wire              done_r,
  input wire              error_r,
  input wire [ADDR_W-1:0] entry_addr_r,
  input wire              started_r,
  input wire [7:0]        rec_count_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Memory holds off while a word waits
  sequence s_stall; mem_valid && !mem_ready; endsequence
  a_word_held: assert property (s_stall |=> mem_valid && $stable(mem_addr) && $stable(mem_data))
    else $error("word moved under stall");
  a_done_sticky: assert property (done_r |=> done_r && $stable(entry_addr_r))
    else $error("done or entry changed");
  a_error_sticky: assert property (error_r |=> error_r && !done_r)
    else $error("error dropped");
  a_busy_ends: assert property (done_r || error_r |=> !busy_r)
    else $error("busy after end");
  a_busy_start: assert property ($rose(started_r) |-> busy_r)
    else $error("busy not raised at start");
  a_ready_free: assert property (!mem_valid |-> char_ready)
    else $error("stalled with empty buffer");
  a_start_sticky: assert property (started_r |=> started_r && rec_count_r != 8'h00)
    else $error("start flag lost");
  // Only a good data record may bump the count, by one
  a_count_step: assert property ($past(rst_n) && rec_count_r != $past(rec_count_r)
    |-> rec_count_r == $past(rec_count_r) + 8'h01 && started_r)
    else $error("record count jump");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> !mem_valid && !done_r && !error_r && !started_r)
    else $error("state after reset");
endmodule

bind srdp_parser srdp_chk #(.ADDR_W(ADDR_W)) i_chk (.core_clk(core_clk), .rst_n(rst_n), .char_valid(char_valid),
  .char_data(char_data), .char_ready(char_ready), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data),
  .mem_ready(mem_ready), .busy_r(busy_r), .done_r(done_r), .error_r(error_r), .entry_addr_r(entry_addr_r),
  .started_r(started_r), .rec_count_r(rec_count_r));

//--- sim/srdp_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host sending ASCII records, one char per handshake
module srdp_host_model (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Character stream
  output logic       char_valid,
  output logic [7:0] char_data,
  input  wire        char_ready
);
  logic [7:0] q[$];
  int         gap = 0;
  int         cnt = 0;
  initial begin
    char_valid = 1'b0;
    char_data  = 8'h00;
  end
  // Raw text goes out as its ASCII codes
  task put(input string s);
    for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
  endtask
  // One record; bad flips checksum bits on purpose
  task rec(input logic [3:0] t, input logic [15:0] a, input string d, input logic [7:0] bad);
    logic [7:0] b;
    logic [7:0] sum;
    sum = 8'(d.len() / 2 + 3);
    put($sformatf("S%0d%02X%04X%s", t, sum, a, d));
    sum = sum + a[15:8] + a[7:0];
    for (int i = 0; i < d.len(); i += 2) begin
      void'($sscanf(d.substr(i, i + 1), "%h", b));
      sum = sum + b;
    end
    put({$sformatf("%02X", ~sum ^ bad), "\r\n"});
  endtask
  // Offer holds until taken; idle data keeps changing so it is never trusted
  always @(posedge core_clk) begin
    if (!rst_n) begin
      char_valid <= 1'b0;
    end else if (!char_valid || char_ready) begin
      if (q.size() != 0 && cnt == 0) begin
        char_valid <= 1'b1;
        char_data  <= q.pop_front();
        cnt        <= gap;
      end else begin
        char_valid <= 1'b0;
        char_data  <= ~char_data;
        if (cnt != 0) cnt <= cnt - 1;
      end
    end
  end
endmodule

//--- sim/srdp_parser_tb_top.sv
`timescale 1ns/1ps
module srdp_parser_tb_top;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        mem_ready = 1'b1;
  wire         char_valid, char_ready, mem_valid, busy_r, done_r, error_r, started_r;
  wire  [7:0]  char_data, mem_data, rec_count_r;
  wire  [15:0] mem_addr, entry_addr_r;
  logic [23:0] exp_q[$];
  int          errors = 0;
  int          checked = 0;
  always #2.5 core_clk = ~core_clk;
  srdp_host_model i_host (.core_clk(core_clk), .rst_n(rst_n), .char_valid(char_valid), .char_data(char_data),
    .char_ready(char_ready));
  srdp_parser i_dut (.core_clk(core_clk), .rst_n(rst_n), .char_valid(char_valid), .char_data(char_data),
    .char_ready(char_ready), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data), .mem_ready(mem_ready),
    .busy_r(busy_r), .done_r(done_r), .error_r(error_r), .entry_addr_r(entry_addr_r), .started_r(started_r),
    .rec_count_r(rec_count_r));
  task check(input string n, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task do_reset;
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  // Every accepted word must be the next one expected
  always @(posedge core_clk) begin
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      check("write", {mem_addr, mem_data}, exp_q.size() != 0 ? exp_q[0] : 24'hXXXXXX);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  // Data record plus the words it should leave in memory
  task s1(input logic [15:0] a, input string d);
    logic [7:0] b;
    i_host.rec(4'h1, a, d, 8'h00);
    for (int i = 0; i < d.len(); i += 2) begin
      void'($sscanf(d.substr(i, i + 1), "%h", b));
      exp_q.push_back({a + 16'(i / 2), b});
    end
  endtask
  // Bounded wait for the host to drain and the parser to settle
  task finish_check(input logic [7:0] n, input logic d, input logic e);
    for (int i = 0; i < 3000 && (i_host.q.size() != 0 || !(done_r || error_r)); i++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    check("records", rec_count_r, n);
    check("end", {done_r, error_r, busy_r}, {d, e, 1'b0});
    check("queue", exp_q.size(), 0);
  endtask
  // Junk, header, foreign type, lowercase hex, end record
  task t_load;
    i_host.put("0100 ");
    i_host.rec(4'h0, 16'h0000, "484452", 8'h00);
    s1(16'h0010, "AB3F");
    i_host.rec(4'h5, 16'h0200, "77", 8'h00);
    i_host.q.push_back(8'h00);
    i_host.put("S10580a0c5d540\n");
    exp_q.push_back(24'h80A0C5);
    exp_q.push_back(24'h80A1D5);
    i_host.rec(4'h9, 16'h1234, "", 8'h00);
    finish_check(8'h02, 1'b1, 1'b0);
    check("entry", entry_addr_r, 16'h1234);
    check("started", started_r, 1'b1);
  endtask
  // Memory stalls until the buffer refuses, then drains
  task t_stall;
    do_reset();
    mem_ready <= 1'b0;
    s1(16'h0400, "0011223344");
    for (int i = 0; i < 300 && char_ready !== 1'b0; i++) @(posedge core_clk);
    check("refuse", char_ready, 1'b0);
    mem_ready <= 1'b1;
    i_host.rec(4'h9, 16'h0400, "", 8'h00);
    finish_check(8'h01, 1'b1, 1'b0);
  endtask
  // Slow host, bad checksum then bad digit
  task t_bad;
    do_reset();
    i_host.gap = 3;
    s1(16'h0020, "55");
    void'(i_host.q.pop_back());
    void'(i_host.q.pop_back());
    void'(i_host.q.pop_back());
    i_host.put("8\r\n");
    finish_check(8'h00, 1'b0, 1'b1);
    do_reset();
    i_host.gap = 0;
    i_host.put("S1040030G155\r\n");
    finish_check(8'h00, 1'b0, 1'b1);
  endtask
  initial begin
    do_reset();
    t_load();
    t_stall();
    t_bad();
    tally_and_finish();
  end
  // Hang guard, well above the expected run
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule
